// *** hdl/rolm_cfg.svh ***
// Constants for the receive output and line monitor block.
// Assumes a 10 MHz system clock; all link signals arrive asynchronously.
//
// How it works
// RULE_01 - The drive monitor raises drive_fault_flag after 128 transmit bit periods without a bipolar pulse.
// RULE_02 - The drive monitor drops drive_fault_flag once a bipolar pulse is seen within the last 128 bit periods.
// RULE_03 - Internal monitoring of the transmit output can only be selected while the device runs in host mode.
// RULE_04 - With internal monitoring selected the monitor tip and ring inputs are ignored.
// RULE_05 - signal_lost_flag is high exactly while the channel declares the loss-of-signal defect.
// RULE_06 - clock_unlocked_flag is high exactly while the channel declares loss of lock.
// RULE_07 - Loss of lock is declared when the recovered clock is off the reference by 0.5 percent or more.
// RULE_08 - The lock reference is the E3 clock in DS3 mode, the STS-1 clock in STS-1 mode, the synthesiser clock in SINGLE_FREQUENCY_MODE.
// RULE_09 - In dual-rail mode the positive output pulses for one recovered clock period per positive line pulse.
// RULE_10 - In dual-rail mode negative pulses appear only on the negative output.
// RULE_11 - In single-rail mode the whole recovered data stream appears on the positive output.
// RULE_12 - Outputs change on a selectable recovered clock edge; the receiver samples on the other edge.
// RULE_13 - In single-rail mode the negative output pulses on a code violation or an excess-zeros event.
// RULE_14 - Each of the three channels has its own copy of the logic; only configuration and references are shared.
`ifndef ROLM_CFG_SVH
`define ROLM_CFG_SVH

`define ROLM_CHANNELS 3
`define ROLM_DMO_BITS 128
`define ROLM_DMO_W 8
`define ROLM_LOL_PPM 5000
`define ROLM_LOL_DIV (1000000 / `ROLM_LOL_PPM)
`define ROLM_LOL_WIN 1024
`define ROLM_WIN_W 11
`define ROLM_REF_W 12
`define ROLM_PROD_W 20
`define ROLM_BUF_DEPTH 2

// Per-channel synchroniser bit positions
`define ROLM_CS_W 13
`define ROLM_CS_RXCLK 0
`define ROLM_CS_RXPOS 1
`define ROLM_CS_RXNEG 2
`define ROLM_CS_CV 3
`define ROLM_CS_EXZ 4
`define ROLM_CS_LOS 5
`define ROLM_CS_TXCLK 6
`define ROLM_CS_TXP 7
`define ROLM_CS_TXN 8
`define ROLM_CS_MTIP 9
`define ROLM_CS_MRING 10
`define ROLM_CS_SRAIL 11
`define ROLM_CS_STS1 12

// Global synchroniser bit positions
`define ROLM_GS_W 7
`define ROLM_GS_E3 0
`define ROLM_GS_STS1 1
`define ROLM_GS_SFMC 2
`define ROLM_GS_HOST 3
`define ROLM_GS_INTMON 4
`define ROLM_GS_SFM 5
`define ROLM_GS_RISE 6

`endif

// *** hdl/rolm_pkg.sv ***
// Types shared by the receive output and line monitor block.
// Assumes rolm_cfg.svh is on the include path.
`include "rolm_cfg.svh"

package rolm_pkg;

  typedef logic [`ROLM_CHANNELS-1:0] rolm_chan_t;

  typedef enum logic [1:0] {
    ROLM_REF_E3 = 2'h0,
    ROLM_REF_STS1 = 2'h1,
    ROLM_REF_SFM = 2'h2
  } rolm_ref_sel_t;

  typedef logic [1:0] rolm_word_t;

endpackage

// *** hdl/rolm_top.sv ***
// Three-channel receive output, alarm flags and transmit drive monitor.
// Assumes every link input is asynchronous to clk and slower than clk / 4.
`timescale 1ns/100ps
`include "rolm_cfg.svh"

module rolm_top (
  input wire logic clk,
  input wire logic reset,
  input wire logic host_mode,
  input wire logic internal_monitor_sel,
  input wire logic single_frequency_mode,
  input wire logic rx_update_rising,
  input wire logic e3_ref_clock,
  input wire logic sts1_ref_clock,
  input wire logic sfm_ref_clock,
  input wire rolm_pkg::rolm_chan_t single_rail_mode,
  input wire rolm_pkg::rolm_chan_t sts1_mode,
  input wire rolm_pkg::rolm_chan_t rx_clock_in,
  input wire rolm_pkg::rolm_chan_t rx_pos_in,
  input wire rolm_pkg::rolm_chan_t rx_neg_in,
  input wire rolm_pkg::rolm_chan_t code_violation,
  input wire rolm_pkg::rolm_chan_t excess_zeros_event,
  input wire rolm_pkg::rolm_chan_t signal_absent_defect,
  input wire rolm_pkg::rolm_chan_t tx_clock_in,
  input wire rolm_pkg::rolm_chan_t tx_line_pos_out,
  input wire rolm_pkg::rolm_chan_t tx_line_neg_out,
  input wire rolm_pkg::rolm_chan_t monitor_tip_in,
  input wire rolm_pkg::rolm_chan_t monitor_ring_in,
  input wire rolm_pkg::rolm_chan_t rx_out_hold,
  output logic [`ROLM_CHANNELS-1:0] rx_clock_out,
  output logic [`ROLM_CHANNELS-1:0] rx_positive_out,
  output logic [`ROLM_CHANNELS-1:0] rx_negative_out,
  output logic [`ROLM_CHANNELS-1:0] rx_buffer_ready,
  output logic [`ROLM_CHANNELS-1:0] signal_lost_flag,
  output logic [`ROLM_CHANNELS-1:0] clock_unlocked_flag,
  output logic [`ROLM_CHANNELS-1:0] drive_fault_flag
);
  import rolm_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Shared decode

  // Picks the rising edge of the lock reference for one channel
  function automatic logic ref_pick(input rolm_ref_sel_t sel, input logic [2:0] rises);
    logic r;
    r = 1'b0;
    case (sel)
      ROLM_REF_E3: r = rises[`ROLM_GS_E3];
      ROLM_REF_STS1: r = rises[`ROLM_GS_STS1];
      ROLM_REF_SFM: r = rises[`ROLM_GS_SFMC];
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Global synchronisers: reference clocks and shared configuration pins

  logic [`ROLM_GS_W-1:0] gs1_q, gs2_q, gs3_q;
  logic [`ROLM_GS_W-1:0] gs1_d, gs2_d, gs3_d;
  logic [2:0] ref_rise;
  logic int_mon_en;
  logic sfm_en;
  logic upd_rising;

  always_comb begin
    gs1_d = {rx_update_rising, single_frequency_mode, internal_monitor_sel, host_mode,
             sfm_ref_clock, sts1_ref_clock, e3_ref_clock};
    gs2_d = gs1_q;
    gs3_d = gs2_q;
    ref_rise = gs2_q[2:0] & ~gs3_q[2:0];
    int_mon_en = gs2_q[`ROLM_GS_HOST] & gs2_q[`ROLM_GS_INTMON]; // RULE_03
    sfm_en = gs2_q[`ROLM_GS_SFM];
    upd_rising = gs2_q[`ROLM_GS_RISE];
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      gs1_q <= '0;
      gs2_q <= '0;
      gs3_q <= '0;
    end else begin
      gs1_q <= gs1_d;
      gs2_q <= gs2_d;
      gs3_q <= gs3_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel logic

  genvar ch;
  generate
    for (ch = 0; ch < `ROLM_CHANNELS; ch++) begin : g_chan // RULE_14
      logic [`ROLM_CS_W-1:0] cs1_q, cs2_q, cs3_q;
      logic [`ROLM_CS_W-1:0] cs1_d, cs2_d, cs3_d;
      rolm_word_t mem_q [`ROLM_BUF_DEPTH];
      rolm_word_t mem_d [`ROLM_BUF_DEPTH];
      logic wr_q, rd_q, wr_d, rd_d;
      logic [1:0] cnt_q, cnt_d;
      logic pos_q, neg_q, rclk_q, rdy_q, los_q, lol_q, dmo_q;
      logic pos_d, neg_d, rclk_d, rdy_d, los_d, lol_d, dmo_d;
      logic [`ROLM_DMO_W-1:0] idle_q, idle_d;
      logic [`ROLM_WIN_W-1:0] win_q, win_d;
      logic [`ROLM_REF_W-1:0] refc_q, refc_d;
      logic rx_rise, rx_fall, upd_edge, push, pop, tx_rise, bip_p, bip_n, ref_edge;
      logic win_end, ref_over;
      logic [`ROLM_REF_W-1:0] ref_next, diff;
      logic [`ROLM_PROD_W-1:0] prod;
      rolm_word_t word_in;
      rolm_ref_sel_t sel;

      always_comb begin
        cs1_d = {sts1_mode[ch], single_rail_mode[ch], monitor_ring_in[ch], monitor_tip_in[ch],
                 tx_line_neg_out[ch], tx_line_pos_out[ch], tx_clock_in[ch], signal_absent_defect[ch],
                 excess_zeros_event[ch], code_violation[ch], rx_neg_in[ch], rx_pos_in[ch], rx_clock_in[ch]};
        cs2_d = cs1_q;
        cs3_d = cs2_q;

        // Recovered clock edges and the selected update edge
        rx_rise = cs2_q[`ROLM_CS_RXCLK] & ~cs3_q[`ROLM_CS_RXCLK];
        rx_fall = ~cs2_q[`ROLM_CS_RXCLK] & cs3_q[`ROLM_CS_RXCLK];
        upd_edge = upd_rising ? rx_rise : rx_fall; // RULE_12
        rclk_d = cs2_q[`ROLM_CS_RXCLK];

        // Word formed from the line pulses at each recovered bit
        if (cs2_q[`ROLM_CS_SRAIL]) begin
          word_in[1] = cs2_q[`ROLM_CS_RXPOS] | cs2_q[`ROLM_CS_RXNEG]; // RULE_11
          word_in[0] = cs2_q[`ROLM_CS_CV] | cs2_q[`ROLM_CS_EXZ]; // RULE_13
        end else begin
          word_in[1] = cs2_q[`ROLM_CS_RXPOS]; // RULE_09
          word_in[0] = cs2_q[`ROLM_CS_RXNEG]; // RULE_10
        end

        // Two-entry buffer between bit capture and output update
        push = rx_rise & (cnt_q != 2'(`ROLM_BUF_DEPTH));
        pop = upd_edge & ~rx_out_hold[ch] & (cnt_q != 2'h0);
        mem_d = mem_q;
        wr_d = wr_q;
        rd_d = rd_q;
        if (push) begin
          mem_d[wr_q] = word_in;
          wr_d = ~wr_q;
        end
        if (pop) begin
          rd_d = ~rd_q;
        end
        cnt_d = cnt_q + 2'(push) - 2'(pop);
        rdy_d = (cnt_d != 2'(`ROLM_BUF_DEPTH));

        // Each output bit stands one full recovered period, from update edge to update edge
        pos_d = pos_q;
        neg_d = neg_q;
        if (upd_edge & ~rx_out_hold[ch]) begin
          pos_d = pop ? mem_q[rd_q][1] : 1'b0; // RULE_09
          neg_d = pop ? mem_q[rd_q][0] : 1'b0; // RULE_10
        end

        // Loss of signal follows the defect directly
        los_d = cs2_q[`ROLM_CS_LOS]; // RULE_05

        // Transmit drive monitor
        tx_rise = cs2_q[`ROLM_CS_TXCLK] & ~cs3_q[`ROLM_CS_TXCLK];
        bip_p = int_mon_en ? cs2_q[`ROLM_CS_TXP] : cs2_q[`ROLM_CS_MTIP]; // RULE_04
        bip_n = int_mon_en ? cs2_q[`ROLM_CS_TXN] : cs2_q[`ROLM_CS_MRING]; // RULE_04
        idle_d = idle_q;
        if (tx_rise) begin
          if (bip_p | bip_n) begin
            idle_d = '0; // RULE_02
          end else if (idle_q != `ROLM_DMO_W'(`ROLM_DMO_BITS)) begin
            idle_d = idle_q + 1'b1;
          end
        end
        dmo_d = (idle_d == `ROLM_DMO_W'(`ROLM_DMO_BITS)); // RULE_01

        // Lock detector: count reference edges over a window of recovered edges
        if (sfm_en) begin
          sel = ROLM_REF_SFM; // RULE_08
        end else if (cs2_q[`ROLM_CS_STS1]) begin
          sel = ROLM_REF_STS1; // RULE_08
        end else begin
          sel = ROLM_REF_E3; // RULE_08
        end
        ref_edge = ref_pick(sel, ref_rise);
        ref_next = refc_q + `ROLM_REF_W'(ref_edge);
        win_end = rx_rise & (win_q == `ROLM_WIN_W'(`ROLM_LOL_WIN - 1));
        ref_over = (ref_next == `ROLM_REF_W'(2 * `ROLM_LOL_WIN));
        if (ref_next >= `ROLM_REF_W'(`ROLM_LOL_WIN)) begin
          diff = ref_next - `ROLM_REF_W'(`ROLM_LOL_WIN);
        end else begin
          diff = `ROLM_REF_W'(`ROLM_LOL_WIN) - ref_next;
        end
        prod = `ROLM_PROD_W'(diff) * `ROLM_PROD_W'(`ROLM_LOL_DIV);
        lol_d = lol_q;
        win_d = win_q + `ROLM_WIN_W'(rx_rise);
        refc_d = ref_next;
        if (ref_over) begin
          lol_d = 1'b1; // RULE_07
          win_d = '0;
          refc_d = '0;
        end else if (win_end) begin
          lol_d = (prod >= `ROLM_PROD_W'(`ROLM_LOL_WIN)); // RULE_07
          win_d = '0;
          refc_d = '0;
        end
      end

      always_ff @(posedge clk) begin
        if (reset) begin
          cs1_q <= '0;
          cs2_q <= '0;
          cs3_q <= '0;
          mem_q <= '{default: '0};
          wr_q <= 1'b0;
          rd_q <= 1'b0;
          cnt_q <= '0;
          pos_q <= 1'b0;
          neg_q <= 1'b0;
          rclk_q <= 1'b0;
          rdy_q <= 1'b1;
          los_q <= 1'b0;
          lol_q <= 1'b1;
          dmo_q <= 1'b0;
          idle_q <= '0;
          win_q <= '0;
          refc_q <= '0;
        end else begin
          cs1_q <= cs1_d;
          cs2_q <= cs2_d;
          cs3_q <= cs3_d;
          mem_q <= mem_d;
          wr_q <= wr_d;
          rd_q <= rd_d;
          cnt_q <= cnt_d;
          pos_q <= pos_d;
          neg_q <= neg_d;
          rclk_q <= rclk_d;
          rdy_q <= rdy_d;
          los_q <= los_d;
          lol_q <= lol_d;
          dmo_q <= dmo_d;
          idle_q <= idle_d;
          win_q <= win_d;
          refc_q <= refc_d;
        end
      end

      assign rx_clock_out[ch] = rclk_q;
      assign rx_positive_out[ch] = pos_q;
      assign rx_negative_out[ch] = neg_q;
      assign rx_buffer_ready[ch] = rdy_q;
      assign signal_lost_flag[ch] = los_q; // RULE_05
      assign clock_unlocked_flag[ch] = lol_q; // RULE_06
      assign drive_fault_flag[ch] = dmo_q; // RULE_01
    end
  endgenerate

endmodule

// *** test/rolm_top_properties.sv ***
// Port checker for rolm_top, bound into every instance.
// Assumes rolm_pkg and rolm_cfg.svh are compiled first.
`timescale 1ns/100ps
`include "rolm_cfg.svh"
module rolm_top_properties (
  input wire logic clk,
  input wire logic reset,
  input wire logic host_mode,
  input wire logic internal_monitor_sel,
  input wire logic rx_update_rising,
  input wire rolm_pkg::rolm_chan_t single_rail_mode,
  input wire rolm_pkg::rolm_chan_t signal_absent_defect,
  input wire rolm_pkg::rolm_chan_t tx_line_pos_out,
  input wire rolm_pkg::rolm_chan_t tx_line_neg_out,
  input wire rolm_pkg::rolm_chan_t monitor_tip_in,
  input wire rolm_pkg::rolm_chan_t monitor_ring_in,
  input wire logic [`ROLM_CHANNELS-1:0] rx_clock_out,
  input wire logic [`ROLM_CHANNELS-1:0] rx_positive_out,
  input wire logic [`ROLM_CHANNELS-1:0] rx_negative_out,
  input wire logic [`ROLM_CHANNELS-1:0] rx_buffer_ready,
  input wire logic [`ROLM_CHANNELS-1:0] signal_lost_flag,
  input wire logic [`ROLM_CHANNELS-1:0] clock_unlocked_flag,
  input wire logic [`ROLM_CHANNELS-1:0] drive_fault_flag
);
  import rolm_pkg::*;
  logic [2:0] age_q, rco_q, sel_e;
  logic [10:0] idle_q;
  logic src0;
  // Channel 0 monitor source as the design should pick it
  assign src0 = host_mode && internal_monitor_sel ? |{tx_line_pos_out[0], tx_line_neg_out[0]} :
    |{monitor_tip_in[0], monitor_ring_in[0]};
  // Recovered clock edge seen in the same sampled cycle as the output change it launches
  assign sel_e = (rx_clock_out ^ rco_q) & (rx_update_rising ? rx_clock_out : ~rx_clock_out);
  always_ff @(posedge clk) begin
    age_q <= reset ? 3'h0 : age_q + 3'(age_q != 3'h7);
    rco_q <= rx_clock_out;
    idle_q <= (reset || src0) ? 11'h0 : idle_q + 11'(idle_q != 11'h7FF);
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  a_los_follows: assert property (age_q == 3'h7 |-> signal_lost_flag == $past(signal_absent_defect, 3))
    else $error("loss of signal flag does not follow its defect");
  a_update_edge: assert property (age_q == 3'h7 |-> (((rx_positive_out ^ $past(rx_positive_out)) |
    (rx_negative_out ^ $past(rx_negative_out))) & ~sel_e) == 3'h0)
    else $error("receive output changed away from the selected edge");
  a_fault_rise: assert property ($rose(drive_fault_flag[0]) |-> idle_q >= 11'h3E8)
    else $error("drive fault raised before 128 idle bit periods");
  a_fault_clear: assert property ($rose(src0) |-> ##[1:20] !drive_fault_flag[0])
    else $error("drive fault kept after transmit activity");
  a_reset_vals: assert property ($fell(reset) |-> clock_unlocked_flag == 3'h7 && drive_fault_flag == 3'h0 &&
    signal_lost_flag == 3'h0 && rx_buffer_ready == 3'h7)
    else $error("outputs not at reset values");
  a_lock_stable: assert property ($changed(clock_unlocked_flag[0]) |=> $stable(clock_unlocked_flag[0]) [*8])
    else $error("lock flag changed between windows");
  a_dual_excl: assert property (!single_rail_mode[2] |-> !(rx_positive_out[2] && rx_negative_out[2]))
    else $error("negative data seen on the positive output");
  a_pulse_len: assert property ($rose(rx_positive_out[2]) |-> rx_positive_out[2] [*6])
    else $error("positive pulse shorter than a recovered period");
endmodule
bind rolm_top rolm_top_properties u_chk (.*);

// *** test/rolm_sink.sv ***
// Receiving terminal: counts ones on the edge opposite to the update edge.
// Assumes rx_clock_out is slow enough to be seen edge by edge on clk.
`timescale 1ns/100ps
module rolm_sink (
  input wire logic clk,
  input wire logic reset,
  input wire logic rx_update_rising,
  input wire logic slow,
  input wire logic [2:0] rx_clock_out,
  input wire logic [2:0] rx_positive_out,
  input wire logic [2:0] rx_negative_out,
  output logic [2:0] rx_out_hold,
  output int cp [3],
  output int cn [3]
);
  logic [2:0] prev_q;
  logic [2:0] hit;
  assign rx_out_hold = {3{slow}};
  assign hit = (rx_clock_out ^ prev_q) & (rx_update_rising ? ~rx_clock_out : rx_clock_out);
  always_ff @(posedge clk) begin
    prev_q <= rx_clock_out;
    for (int i = 0; i < 3; i++) begin
      cp[i] <= reset ? 0 : cp[i] + int'(hit[i] & rx_positive_out[i]);
      cn[i] <= reset ? 0 : cn[i] + int'(hit[i] & rx_negative_out[i]);
    end
  end
endmodule

// *** test/rolm_top_test.sv ***
// Bench for rolm_top: rx traffic with lock checks, drive monitor and loss of signal.
// Assumes rolm_sink as the receiving terminal and the bound port checker.
`timescale 1ns/100ps
module rolm_top_test;
  import rolm_pkg::*;
  logic clk = 0, reset = 1, host_mode = 0, internal_monitor_sel = 1, single_frequency_mode = 0, rx_update_rising = 0;
  logic e3_ref_clock = 0, sts1_ref_clock = 0, sfm_ref_clock = 0, txc = 0, run = 0, slow = 0;
  rolm_chan_t single_rail_mode = '0, sts1_mode = '0, rx_clock_in = '0, rx_pos_in = '0, rx_neg_in = '0;
  rolm_chan_t code_violation = '0, excess_zeros_event = '0, signal_absent_defect = '0;
  rolm_chan_t tx_line_pos_out = '0, tx_line_neg_out = '0;
  rolm_chan_t monitor_tip_in = '0, monitor_ring_in = '0, tx_clock_in, rx_out_hold;
  logic [2:0] rx_clock_out, rx_positive_out, rx_negative_out, rx_buffer_ready;
  logic [2:0] signal_lost_flag, clock_unlocked_flag, drive_fault_flag, r;
  int error_cnt = 0, check_count = 0, np[3] = '{0, 0, 0}, nn[3] = '{0, 0, 0}, cp[3], cn[3], c, v;
  assign tx_clock_in = {3{txc}};
  rolm_top u_dut (.*);
  rolm_sink u_sink (.*);
  initial forever #50 clk = ~clk;
  // E3 reference stops in single-frequency mode so only the synthesiser clock can keep lock
  initial forever #400 {e3_ref_clock, sfm_ref_clock} = {~e3_ref_clock & ~single_frequency_mode, ~sfm_ref_clock};
  initial forever #420 sts1_ref_clock = ~sts1_ref_clock;
  initial #33 forever #400 txc = ~txc;
  initial #137 forever #400 rx_clock_in = run ? ~rx_clock_in : 3'h0;
  ////////////////////////////////////////
  task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  task automatic conclude;
    if (error_cnt == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // n recovered bits per channel, or zeros to flush the buffer
  task automatic bits(int n, bit z);
    for (int k = 0; k < n; k++) begin
      @(negedge rx_clock_in[0]) @(posedge clk) #1;
      for (int i = 0; i < 3; i++) begin
        c = z ? 0 : $urandom % 4;
        v = z ? 0 : $urandom % 4;
        {rx_pos_in[i], rx_neg_in[i], code_violation[i], excess_zeros_event[i]} = {c == 1, c == 2, v[0], v[1]};
        np[i] += single_rail_mode[i] ? int'(c == 1 || c == 2) : int'(c == 1);
        nn[i] += single_rail_mode[i] ? int'(v != 0) : int'(c == 2);
      end
    end
  endtask
  task automatic tx(int n, logic [2:0] ai, logic [2:0] ae, logic [2:0] f);
    for (int k = 0; k < n; k++) begin
      @(negedge txc) @(posedge clk) #1 r = 3'($urandom);
      {tx_line_pos_out, tx_line_neg_out} = {ai & r, ai & ~r};
      r = 3'($urandom);
      {monitor_tip_in, monitor_ring_in} = {ae & r, ae & ~r};
    end
    signal_absent_defect = 3'($urandom);
    @(negedge txc) repeat (6) @(posedge clk);
    #1;
    chk("drive_fault_flag", drive_fault_flag, f);
    chk("signal_lost_flag", signal_lost_flag, signal_absent_defect);
  endtask
  task automatic phase(logic [2:0] ul);
    run = 1;
    bits(2100, 0);
    chk("clock_unlocked_flag", clock_unlocked_flag, ul);
    bits(3, 1);
    run = 0;
    repeat (30) @(posedge clk);
    #1;
    for (int i = 0; i < 3; i++) begin
      chk("positive count", cp[i], np[i]);
      chk("negative count", cn[i], nn[i]);
    end
  endtask
  ////////////////////////////////////////
  initial begin
    void'($urandom(66751));
    repeat (20) @(posedge clk);
    #1 reset = 0;
    fork
      begin
        phase(3'h0);
        {single_rail_mode, sts1_mode, rx_update_rising} = {3'h3, 3'h1, 1'b1};
        phase(3'h1);
        {single_frequency_mode, single_rail_mode, rx_update_rising} = {1'b1, 3'h0, 1'b0};
        phase(3'h0);
      end
      begin
        tx(2, 3'h0, 3'h7, 3'h0);
        tx(127, 3'h0, 3'h6, 3'h0);
        tx(0, 3'h0, 3'h6, 3'h1);
        tx(2, 3'h0, 3'h7, 3'h0);
        host_mode = 1;
        tx(140, 3'h7, 3'h0, 3'h0);
        tx(140, 3'h3, 3'h7, 3'h4);
      end
    join
    {slow, run} = 2'h3;
    bits(6, 0);
    chk("rx_buffer_ready full", rx_buffer_ready, 3'h0);
    slow = 0;
    bits(4, 1);
    run = 0;
    repeat (30) @(posedge clk);
    #1;
    chk("rx_buffer_ready drained", rx_buffer_ready, 3'h7);
    conclude;
  end
  initial begin
    #8000000;
    error_cnt++;
    conclude;
  end
endmodule
